/* File: logic/eip_consts.vh */
// Functional notes
// [RL1] Each event gives one low pulse, 100 us
// [RL2] Pin stays high at least 100 us between pulses
// [RL3] Pulses never change the operating mode
// [RL4] Class 0: only wake status and unmasked CAN timeout events interrupt
// [RL5] Wake events count only if source enabled
// [RL6] CAN timeout gated by its own mask only
// [RL7] Class 1 adds failures; level status never
// [RL8] Restart/fail-safe, reset, state bits never interrupt
// [RL9] Stop entry with wake bits set pulses
// [RL10] Status registers update at pulse falling edge; can_timeout_status sets on the event cycle instead
// [RL11] Events latched until host reads and clears
// [RL12] Host may reread after clear to confirm
// [RL13] Init mode samples pin, filtered 10 us
// [RL14] Measurement mode blocks wake inputs one, two
// [RL15] Requests during pulse or gap stay pending
// [RL16] Timings counted in oscillator cycles
`ifndef EIP_CONSTS_VH
`define EIP_CONSTS_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EIP_CLK_MHZ 250
`define EIP_PULSE_US 100
`define EIP_GAP_US 100
`define EIP_CFG_FILT_US 10
`define EIP_PULSE_CYC (`EIP_PULSE_US * `EIP_CLK_MHZ)
`define EIP_GAP_CYC (`EIP_GAP_US * `EIP_CLK_MHZ)
`define EIP_CFG_FILT_CYC (`EIP_CFG_FILT_US * `EIP_CLK_MHZ)
`define EIP_CNT_W 16
// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define EIP_WAKE_W 8
`define EIP_FAIL_W 8
`define EIP_WK1_BIT 0
`define EIP_WK2_BIT 1
`define EIP_RST_WAKE 8'h00
`define EIP_RST_FAIL 8'h00
`endif

/* File: logic/eip_sticky.v */
`include "eip_consts.vh"
// ----------------------------------------------------------------
// Sticky status byte: hardware set wins over host clear
// ----------------------------------------------------------------
module eip_sticky #(
	parameter W = 8
) (
	input wire clock,
	input wire nrst,
	input wire [W-1:0] set_bits,
	input wire [W-1:0] clr_bits,
	input wire commit,
	output reg [W-1:0] pend_reg,
	output reg [W-1:0] stat_reg
);
	// Pending holds events; visible copy loaded on commit, host clears apply in any cycle
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pend_reg <= {W{1'b0}};
			stat_reg <= {W{1'b0}};
		end else begin
			pend_reg <= (pend_reg & ~clr_bits) | set_bits; // [RL11]
			if (commit) begin
				stat_reg <= (pend_reg & ~clr_bits) | set_bits; // [RL10]
			end else begin
				stat_reg <= stat_reg & ~clr_bits; // [RL11]
			end
		end
	end
endmodule // eip_sticky

/* File: logic/eip_pulser.v */
`include "eip_consts.vh"
// ----------------------------------------------------------------
// Interrupt pulse generator with status capture
// ----------------------------------------------------------------
module eip_pulser (
	input wire clock,
	input wire nrst,
	input wire mode_normal,
	input wire mode_stop,
	input wire mode_init,
	input wire stop_cmd,
	input wire class_global,
	input wire can_timeout_irq_mask,
	input wire voltage_measure_enable,
	input wire [7:0] wake_first_ev,
	input wire [7:0] wake_first_en,
	input wire [7:0] wake_second_ev,
	input wire [7:0] wake_second_en,
	input wire can_timeout_event,
	input wire [7:0] fail_ev,
	input wire [7:0] fail_int_capable,
	input wire [7:0] wake_first_clr,
	input wire [7:0] wake_second_clr,
	input wire [7:0] fail_clr,
	input wire can_timeout_clr,
	input wire int_pin_in,
	output reg int_pin_out,
	output wire int_pin_oe,
	output wire [7:0] wake_status_first,
	output wire [7:0] wake_status_second,
	output wire [7:0] fail_status,
	output reg can_timeout_status,
	output reg hw_config_reg,
	output reg hw_config_valid
);
	// ----------------------------------------------------------------
	// States, one-hot
	// ----------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_PULSE = 3'h2;
	localparam [2:0] ST_GAP = 3'h4;
	localparam [`EIP_CNT_W-1:0] PULSE_CYC = `EIP_PULSE_CYC; // [RL16]
	localparam [`EIP_CNT_W-1:0] GAP_CYC = `EIP_GAP_CYC; // [RL16]
	localparam [`EIP_CNT_W-1:0] CFG_CYC = `EIP_CFG_FILT_CYC; // [RL16]
	localparam [`EIP_CNT_W-1:0] ONE = 16'h0001;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [`EIP_CNT_W-1:0] cnt_reg; // Pulse and gap timer
	reg [`EIP_CNT_W-1:0] cnt_next;
	reg pend_reg; // Request waiting for the gap to expire
	reg [`EIP_CNT_W-1:0] cfg_cnt_reg; // Config filter timer
	reg cfg_last_reg; // Last sampled pin level in init
	wire [7:0] wake_first_pend;
	wire [7:0] wake_second_pend;
	wire [7:0] fail_pend;
	wire [7:0] wk1_gate; // Measurement mode masks wake one and two
	wire [7:0] wk_first_set;
	wire [7:0] wk_second_set;
	wire [7:0] fail_set;
	wire cto_set;
	wire commit; // Falling edge of the pulse
	wire irq_active; // Pulses only in normal or stop mode
	wire new_event;
	wire stop_req;
	wire request;

	// ----------------------------------------------------------------
	// Event qualification
	// ----------------------------------------------------------------
	// Measurement function removes wake one and two from status
	assign wk1_gate = voltage_measure_enable ?
		~(8'h01 << `EIP_WK1_BIT | 8'h01 << `EIP_WK2_BIT) : 8'hFF; // [RL14]
	assign wk_first_set = wake_first_ev & wake_first_en & wk1_gate; // [RL5]
	assign wk_second_set = wake_second_ev & wake_second_en; // [RL5]
	// Restart/fail-safe causes arrive with capable bit low
	assign fail_set = fail_ev & fail_int_capable; // [RL8]
	assign cto_set = can_timeout_event;
	assign irq_active = mode_normal | mode_stop;
	// Class 1 adds failures; CAN timeout follows its mask alone
	assign new_event = (|wk_first_set) | (|wk_second_set) | // [RL4]
		(cto_set & ~can_timeout_irq_mask) | // [RL6]
		(class_global & (|fail_set)); // [RL7]
	assign stop_req = stop_cmd & ((|wake_first_pend) | (|wake_second_pend)); // [RL9]
	assign request = new_event | stop_req;
	assign commit = (state_reg == ST_IDLE) & irq_active & (pend_reg | request);

	// ----------------------------------------------------------------
	// Latched status
	// ----------------------------------------------------------------
	eip_sticky #(.W(8)) u_wk1 (
		.clock(clock),
		.nrst(nrst),
		.set_bits(wk_first_set),
		.clr_bits(wake_first_clr),
		.commit(commit),
		.pend_reg(wake_first_pend),
		.stat_reg(wake_status_first)
	);
	eip_sticky #(.W(8)) u_wk2 (
		.clock(clock),
		.nrst(nrst),
		.set_bits(wk_second_set),
		.clr_bits(wake_second_clr),
		.commit(commit),
		.pend_reg(wake_second_pend),
		.stat_reg(wake_status_second)
	);
	eip_sticky #(.W(8)) u_fail (
		.clock(clock),
		.nrst(nrst),
		.set_bits(fail_set),
		.clr_bits(fail_clr),
		.commit(commit),
		.pend_reg(fail_pend),
		.stat_reg(fail_status)
	);

	// CAN timeout flag: set wins over clear
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			can_timeout_status <= 1'b0;
		end else begin
			can_timeout_status <= (can_timeout_status & ~can_timeout_clr) | cto_set; // [RL11]
		end
	end

	// ----------------------------------------------------------------
	// Pulse state machine; mode inputs are read, never written
	// ----------------------------------------------------------------
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_IDLE: begin
				if (commit) begin
					state_next = ST_PULSE; // [RL1]
					cnt_next = PULSE_CYC - ONE;
				end
			end
			ST_PULSE: begin
				if (cnt_reg == 16'h0000) begin
					state_next = ST_GAP; // [RL2]
					cnt_next = GAP_CYC - ONE;
				end else begin
					cnt_next = cnt_reg - ONE;
				end
			end
			ST_GAP: begin
				if (cnt_reg == 16'h0000) begin
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - ONE;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = 16'h0000;
			end
		endcase
	end

	// State, timer and pending request; pin is registered
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 16'h0000;
			pend_reg <= 1'b0;
			int_pin_out <= 1'b1;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (commit) begin
				pend_reg <= 1'b0;
			end else if (request) begin
				pend_reg <= 1'b1; // [RL15]
			end
			int_pin_out <= (state_next != ST_PULSE); // [RL3]
		end
	end

	// Push/pull output driven outside init so config can be read
	assign int_pin_oe = ~mode_init;

	// ----------------------------------------------------------------
	// Configuration select: pin level must be stable 10 us in init
	// ----------------------------------------------------------------
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cfg_cnt_reg <= 16'h0000;
			cfg_last_reg <= 1'b0;
			hw_config_reg <= 1'b0;
			hw_config_valid <= 1'b0;
		end else if (mode_init) begin
			cfg_last_reg <= int_pin_in;
			if (int_pin_in != cfg_last_reg) begin
				cfg_cnt_reg <= 16'h0000; // Restart filter on any change
			end else if (cfg_cnt_reg == CFG_CYC - ONE) begin
				hw_config_reg <= cfg_last_reg; // [RL13]
				hw_config_valid <= 1'b1;
			end else begin
				cfg_cnt_reg <= cfg_cnt_reg + ONE;
			end
		end else begin
			cfg_cnt_reg <= 16'h0000;
		end
	end
endmodule // eip_pulser

/* File: bench/eip_chk_sva.sv */
// ----------------
// Pin timing, status and config checker
// ----------------
module eip_chk (
	input wire clock,
	input wire nrst,
	input wire mode_normal,
	input wire mode_stop,
	input wire mode_init,
	input wire int_pin_in,
	input wire int_pin_out,
	input wire int_pin_oe,
	input wire [7:0] wake_status_first,
	input wire [7:0] wake_status_second,
	input wire [7:0] fail_status,
	input wire hw_config_reg,
	input wire hw_config_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PULSE = 25000;
	reg [15:0] lo_reg; // Low run length
	reg [15:0] hi_reg; // High run length, saturates so reset counts as a long gap
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Run counters on the pin drive
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			lo_reg <= 16'h0000;
			hi_reg <= 16'hFFFF;
		end else begin
			lo_reg <= int_pin_out ? 16'h0000 : lo_reg + 16'h0001;
			hi_reg <= int_pin_out ? hi_reg + {15'h0000, ~&hi_reg} : 16'h0000;
		end
	end
	chk_pulse_width: assert property ($rose(int_pin_out) |-> lo_reg == PULSE)
		else $error("pulse width wrong");
	chk_low_bound: assert property (lo_reg <= PULSE)
		else $error("pulse too long");
	chk_pulse_mode: assert property ($fell(int_pin_out) |-> mode_normal || mode_stop)
		else $error("pulse outside normal or stop");
	chk_min_gap: assert property ($fell(int_pin_out) |-> hi_reg >= PULSE)
		else $error("gap too short");
	chk_gap_hold: assert property ($rose(int_pin_out) |-> int_pin_out [*8])
		else $error("pin fell right after release");
	chk_status_edge: assert property ((|(wake_status_first & ~$past(wake_status_first)))
		|| (|(wake_status_second & ~$past(wake_status_second)))
		|| (|(fail_status & ~$past(fail_status))) |-> $fell(int_pin_out))
		else $error("status set away from falling edge");
	chk_oe_init: assert property (int_pin_oe == !mode_init)
		else $error("pin drive wrong for mode");
	chk_cfg_init: assert property ($rose(hw_config_valid) |-> $past(mode_init))
		else $error("config taken outside init");
	chk_cfg_level: assert property ($rose(hw_config_valid) |-> hw_config_reg == $past(int_pin_in))
		else $error("config level wrong");
	cover property ($fell(int_pin_out));
	cover property ($rose(hw_config_valid));
	cover property ($fell(int_pin_out) && hi_reg == PULSE);
endmodule // eip_chk
bind eip_pulser eip_chk u_chk (.*);

/* File: bench/eip_host.sv */
// ----------------
// Host side: config level and pin timing
// ----------------
module eip_host (
	input wire logic clock,
	input wire logic int_pin_in,
	output logic cfg_level,
	output int low_len,
	output int gap_len
);
	timeunit 1ns;
	timeprecision 1ps;
	int run = 0; // Samples at the current level
	logic last = 1'b1; // Level at the previous edge
	assign cfg_level = 1'b1;
	// Measure each low and high stretch of the pin
	always @(posedge clock) begin
		if (int_pin_in !== last) begin
			if (last) gap_len <= run;
			else low_len <= run;
			run <= 1;
		end else begin
			run <= run + 1;
		end
		last <= int_pin_in;
	end
endmodule // eip_host

/* File: bench/event_interrupt_pulser_bench.sv */
module event_interrupt_pulser_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// Signals
	// ----------------
	logic clock = 1'b0;
	logic nrst, mode_normal, mode_stop, mode_init, stop_cmd, class_global;
	logic can_timeout_irq_mask, voltage_measure_enable, can_timeout_event, can_timeout_clr;
	logic [7:0] wake_first_ev, wake_first_en, wake_second_ev, wake_second_en;
	logic [7:0] fail_ev, fail_int_capable, wake_first_clr, wake_second_clr, fail_clr;
	wire int_pin_out, int_pin_oe, can_timeout_status, hw_config_reg, hw_config_valid;
	wire [7:0] wake_status_first, wake_status_second, fail_status;
	wire int_pin_in, cfg_level;
	int low_len, gap_len, n_errors = 0, samples_checked = 0;
	logic [7:0] cap, wf, ws, fe;
	// Device drives the pin except in init, where the host level decides
	assign int_pin_in = int_pin_oe ? int_pin_out : cfg_level;
	always #2 clock = ~clock;
	eip_pulser DUT (.*);
	eip_host host (.*);
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// One-cycle events, then watch the pin stay high for hush cycles
	task automatic fire(input logic [7:0] a, b, c, input logic d, input int hush);
		@(negedge clock);
		{wake_first_ev, wake_second_ev, fail_ev, can_timeout_event} = {a, b, c, d};
		@(negedge clock);
		{wake_first_ev, wake_second_ev, fail_ev, can_timeout_event} = '0;
		repeat (hush) begin
			@(negedge clock);
			chk(int_pin_in, 1, "unexpected pulse");
		end
		if (hush > 0) $display("test done: quiet");
	endtask
	// Bounded wait for a pin level; running out ends the run
	task automatic wait_pin(input logic v, input int lim);
		for (int i = 0; i < lim && int_pin_in !== v; i++) @(negedge clock);
		if (int_pin_in !== v) begin
			n_errors++;
			$display("mismatch at %0t: pin wait ran out", $time);
			give_verdict();
		end
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		{nrst, mode_normal, mode_stop, stop_cmd, class_global, can_timeout_irq_mask} = '0;
		{voltage_measure_enable, can_timeout_event, can_timeout_clr, wake_first_ev} = '0;
		{wake_first_en, wake_second_ev, wake_second_en, fail_ev, fail_int_capable} = '0;
		{wake_first_clr, wake_second_clr, fail_clr} = '0;
		mode_init = 1'b1;
		cap = 8'($urandom(32'h91B7)) | 8'h01;
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		for (int i = 0; i < 4000 && hw_config_valid !== 1'b1; i++) @(negedge clock);
		chk(hw_config_valid, 1, "config not valid");
		chk(hw_config_reg, 1, "config level");
		$display("test done: config");
		{mode_init, mode_normal, class_global} = 3'h3;
		{voltage_measure_enable, can_timeout_irq_mask} = 2'h3;
		fail_int_capable = cap;
		wake_first_en = 8'h0F;
		wake_second_en = 8'hFF;
		fire(8'h00, 8'h00, ~cap, 1'b0, 60);
		class_global = 1'b0;
		fire(8'h00, 8'h00, cap, 1'b0, 60);
		fire(8'h03, 8'h00, 8'h00, 1'b0, 60);
		voltage_measure_enable = 1'b0;
		fire(8'hF0, 8'h00, 8'h00, 1'b1, 60);
		wf = 8'($urandom) & 8'h0F | 8'h04;
		can_timeout_irq_mask = 1'b0;
		fire(wf, 8'h00, 8'h00, 1'b1, 0);
		wait_pin(1'b0, 20);
		chk(wake_status_first & 8'h0F, wf, "wake first status");
		chk(can_timeout_status, 1, "timeout status");
		ws = 8'($urandom) | 8'h01;
		fe = (8'($urandom) | 8'h01) & cap;
		class_global = 1'b1;
		fire(8'h00, ws, fe, 1'b0, 0);
		chk(wake_status_second, 8'h00, "status moved mid pulse");
		wait_pin(1'b1, 26000);
		// Host model latches the run length one edge after the pin moves
		@(negedge clock);
		chk(16'(low_len), 25000, "pulse width");
		wait_pin(1'b0, 26000);
		@(negedge clock);
		// Gap timer plus the idle cycle in which the pending request commits
		chk(16'(gap_len), 25001, "gap length");
		chk(wake_status_second, ws, "pending wake");
		chk(fail_status & fe, fe, "failure status");
		// Stop entry with wake bits still set must add one more pulse
		{mode_normal, mode_stop, stop_cmd} = 3'h3;
		@(negedge clock);
		stop_cmd = 1'b0;
		wait_pin(1'b1, 26000);
		wait_pin(1'b0, 26000);
		chk(int_pin_in, 0, "stop entry pulse");
		chk(mode_stop, 1, "mode kept");
		$display("test done: stop entry");
		@(negedge clock);
		{wake_first_clr, wake_second_clr, fail_clr, can_timeout_clr} = '1;
		@(negedge clock);
		{wake_first_clr, wake_second_clr, fail_clr, can_timeout_clr} = '0;
		@(negedge clock);
		chk({wake_status_first, wake_status_second}, 16'h0000, "wake cleared");
		chk({fail_status, can_timeout_status}, 16'h0000, "fail cleared");
		$display("test done: pulses");
		give_verdict();
	end
endmodule // event_interrupt_pulser_bench
